// ===== design/mbenc_handler.sv
/*
 * Slave handler for the 62h enumeration-text query and the 7Dh encapsulated
 * command. Assumes a byte framer delivering rxValid/rxByte with frameEnd on
 * the last byte, and a transmitter taking txByte when txValid and txReady.
 * Setting lookup answers combinationally on paramOk/indexOk/textByte.
 */
`timescale 1ns/1ps
`default_nettype none
module mbenc_handler #(
    parameter logic [7:0] SLAVE_ADDR = 8'h01,
    parameter int         DEPTH      = mbenc_pkg::BUF_DEPTH
) (
    input  wire logic        mclk,
    input  wire logic        resetn,
    input  wire logic        rxValid,
    input  wire logic [7:0]  rxByte,
    input  wire logic        frameEnd,
    output logic             txValid,
    output logic      [7:0]  txByte,
    input  wire logic        txReady,
    output logic             txLast,
    output logic      [15:0] logicCommand,
    output logic             logicCommandWr,
    input  wire logic [15:0] statusLow,
    input  wire logic [15:0] statusHigh,
    output logic      [15:0] paramNumber,
    output logic      [7:0]  enumIndex,
    output logic      [3:0]  textIdx,
    input  wire logic        paramOk,
    input  wire logic        indexOk,
    input  wire logic [7:0]  textByte,
    output logic      [15:0] cntInvalidAddr,
    output logic      [15:0] cntIllegalReg,
    output logic      [15:0] cntIllegalFunc
);
    typedef enum logic [4:0] {
        ST_RX   = 5'b00001,
        ST_CHK  = 5'b00010,
        ST_EXEC = 5'b00100,
        ST_WAIT = 5'b01000,
        ST_TX   = 5'b10000
    } mbenc_state_t;

    mbenc_state_t state;
    mbenc_state_t next_state;

    logic [7:0]  rxBuf [DEPTH];
    logic [8:0]  rxCnt;
    logic [7:0]  txIdx;
    logic [7:0]  txLen;
    logic [7:0]  txHdr [6];
    logic [1:0]  txKind;
    logic        crcHi;
    logic [15:0] rxCrc;
    logic [15:0] txCrc;
    logic        txCrcPhase;

    mbenc_emb_if emb ();

    mbenc_emb_engine u_engine (
        .mclk   (mclk),
        .resetn (resetn),
        .emb    (emb)
    );

    // Received CRC is over every byte; a good frame leaves zero residue
    mbenc_crc16 u_rx_crc (
        .mclk   (mclk),
        .resetn (resetn),
        .clear  (state == ST_TX && next_state == ST_RX),
        .byteEn (rxValid && state == ST_RX),
        .dataIn (rxByte),
        .crc    (rxCrc)
    );

    wire       txFire   = txValid && txReady;
    wire       txPayload = txFire && !txCrcPhase;
    mbenc_crc16 u_tx_crc (
        .mclk   (mclk),
        .resetn (resetn),
        .clear  (state == ST_EXEC),
        .byteEn (txPayload),
        .dataIn (txByte),
        .crc    (txCrc)
    );

    // Frame decode
    wire [7:0] fAddr    = rxBuf[0];
    wire [7:0] fCode    = rxBuf[1];
    wire       addrHit  = (fAddr == SLAVE_ADDR);
    wire       crcGood  = (rxCrc == 16'h0000);
    wire       isText   = (fCode == mbenc_pkg::FC_ENUM_TEXT) && (rxCnt == 9'd7);
    wire       isEncap  = (fCode == mbenc_pkg::FC_ENCAP) && (rxCnt >= 9'd7)
                          && (rxCnt <= 9'(7 + mbenc_pkg::MAX_DATA));
    wire       accept   = addrHit && crcGood && (isText || isEncap);
    wire [15:0] ctrlWord = {rxBuf[2], rxBuf[3]};
    wire [15:0] statSel  = ctrlWord[mbenc_pkg::STATUS_SEL_BIT] ? statusHigh : statusLow;

    localparam logic [1:0] K_TEXT  = 2'd0;
    localparam logic [1:0] K_TEXTX = 2'd1;
    localparam logic [1:0] K_ENC   = 2'd2;
    localparam logic [1:0] K_ENCX  = 2'd3;

    assign paramNumber = {rxBuf[2], rxBuf[3]};
    assign enumIndex   = rxBuf[4];

    assign emb.func   = rxBuf[4];
    assign emb.lenIn  = 8'(rxCnt - 9'd7);
    assign emb.rdByte = rxBuf[8'(emb.rdIdx + 8'd5)];
    assign emb.req    = (state == ST_EXEC) && isEncap;

    // Outgoing byte selection
    // Text bytes start after the five echoed header bytes
    wire [7:0] bodyIdx  = txIdx - 8'd5;
    assign textIdx    = bodyIdx[3:0];
    assign emb.outIdx = txIdx - 8'd5;
    always_comb begin
        if (txCrcPhase) begin
            txByte = crcHi ? txCrc[15:8] : txCrc[7:0];
        end else if (txKind == K_TEXT && !(txIdx < 8'd5)) begin
            txByte = (txIdx == 8'd4) ? txHdr[4] : textByte;
        end else if (txKind == K_ENC && !(txIdx < 8'd5)) begin
            txByte = emb.outByte;
        end else begin
            txByte = txHdr[txIdx[2:0]];
        end
    end
    assign txValid = (state == ST_TX) && (txLen != 8'd0);
    assign txLast  = txFire && txCrcPhase && crcHi;

    always_comb begin
        next_state = state;
        case (state)
            ST_RX: begin
                if (rxValid && frameEnd) begin
                    next_state = ST_CHK;
                end
            end
            ST_CHK: begin
                next_state = accept ? ST_EXEC : ST_TX;
            end
            ST_EXEC: begin
                next_state = isEncap ? ST_WAIT : ST_TX;
            end
            ST_WAIT: begin
                if (emb.done) begin
                    next_state = ST_TX;
                end
            end
            ST_TX: begin
                if (txLast || txLen == 8'd0) begin
                    next_state = ST_RX;
                end
            end
            default: begin
                next_state = ST_RX;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state <= ST_RX;
        end else begin
            state <= next_state;
        end
    end

    // Receive buffer
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rxCnt <= 9'd0;
            for (int i = 0; i < DEPTH; i++) begin
                rxBuf[i] <= 8'h00;
            end
        end else if (state == ST_RX && rxValid) begin
            rxBuf[rxCnt[7:0]] <= rxCnt[8] ? rxBuf[rxCnt[7:0]] : rxByte;
            rxCnt        <= (rxCnt == 9'h1FF) ? rxCnt : rxCnt + 9'd1;
        end else if (state == ST_TX && next_state == ST_RX) begin
            rxCnt <= 9'd0;
        end
    end

    // Reply framing, counters and control word
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            txLen          <= 8'd0;
            txKind         <= K_TEXT;
            for (int i = 0; i < 6; i++) begin
                txHdr[i] <= 8'h00;
            end
            logicCommand   <= mbenc_pkg::CMD_RESET;
            logicCommandWr <= 1'b0;
            cntInvalidAddr <= 16'h0000;
            cntIllegalReg  <= 16'h0000;
            cntIllegalFunc <= 16'h0000;
        end else begin
            logicCommandWr <= 1'b0;
            if (state == ST_CHK) begin
                txLen <= 8'd0;
            end
            if (state == ST_EXEC && isText) begin
                txHdr[0] <= SLAVE_ADDR;
                txHdr[2] <= rxBuf[2];
                txHdr[3] <= rxBuf[3];
                txHdr[4] <= rxBuf[4];
                if (!paramOk) begin
                    txKind   <= K_TEXTX;
                    txHdr[1] <= mbenc_pkg::FC_ENUM_TEXT | mbenc_pkg::ERR_FLAG;
                    txHdr[2] <= mbenc_pkg::EXC_ILL_ADDR;
                    txLen    <= 8'd3;
                    cntInvalidAddr <= cntInvalidAddr + 16'd1;
                end else if (!indexOk) begin
                    txKind   <= K_TEXTX;
                    txHdr[1] <= mbenc_pkg::FC_ENUM_TEXT | mbenc_pkg::ERR_FLAG;
                    txHdr[2] <= mbenc_pkg::EXC_ILL_DATA;
                    txLen    <= 8'd3;
                    cntIllegalReg <= cntIllegalReg + 16'd1;
                end else begin
                    txKind   <= K_TEXT;
                    txHdr[1] <= mbenc_pkg::FC_ENUM_TEXT;
                    txLen    <= 8'(5 + mbenc_pkg::ENUM_TEXT_LEN);
                end
            end
            if (state == ST_EXEC && isEncap) begin
                logicCommand   <= ctrlWord;
                logicCommandWr <= 1'b1;
                txHdr[0] <= SLAVE_ADDR;
                txHdr[1] <= mbenc_pkg::FC_ENCAP;
                txHdr[2] <= statSel[15:8];
                txHdr[3] <= statSel[7:0];
            end
            if (state == ST_WAIT && emb.done) begin
                if (emb.fail) begin
                    txKind   <= K_ENCX;
                    txHdr[4] <= emb.func | mbenc_pkg::ERR_FLAG;
                    txHdr[5] <= emb.excCode;
                    txLen    <= 8'd6;
                    if (emb.excCode == mbenc_pkg::EXC_ILL_FUNC) begin
                        cntIllegalFunc <= cntIllegalFunc + 16'd1;
                    end
                end else begin
                    txKind   <= K_ENC;
                    txHdr[4] <= emb.func;
                    txLen    <= 8'(8'd5 + emb.lenOut);
                end
            end
        end
    end

    // Transmit position
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            txIdx      <= 8'd0;
            txCrcPhase <= 1'b0;
            crcHi      <= 1'b0;
        end else if (state != ST_TX) begin
            txIdx      <= 8'd0;
            txCrcPhase <= 1'b0;
            crcHi      <= 1'b0;
        end else if (txFire) begin
            if (txCrcPhase) begin
                crcHi <= 1'b1;
            end else if (txIdx + 8'd1 == txLen) begin
                txCrcPhase <= 1'b1;
            end else begin
                txIdx <= txIdx + 8'd1;
            end
        end
    end
endmodule
`default_nettype wire

// ===== common/mbenc_pkg.sv
/*
 * Constants for the enumeration-text and encapsulated-command handler.
 * Assumes a byte-stream framer outside that marks frame start and end.
 */
// Summary of operation
// - Text reply echoes address, code, parameter, index, 16 text bytes, CRC.
// - One text query returns exactly one enumeration entry.
// - Unreadable parameter answers exception 02h and bumps invalid-address count.
// - Bad enumeration index answers exception 03h and bumps illegal-register count.
// - 7Dh applies the control word and runs one embedded function.
// - 7Dh reply status word is status_word_low or status_word_high, picked by control bit 3.
// - Good 7Dh reply echoes embedded code, its reply data, then CRC.
// - Failed embedded function gives flagged code, one error byte, CRC.
// - Unsupported embedded code gives illegal function and bumps its counter.
// - Supported embedded function failing returns that function's own exception.
// - 7Eh does nothing; used inside 7Dh to apply only the control word.
// - 7Dh with 7Eh replies address, 7Dh, status, 7Eh, CRC only.
package mbenc_pkg;
    localparam logic [7:0]  FC_ENUM_TEXT   = 8'h62;
    localparam logic [7:0]  FC_ENCAP       = 8'h7D;
    localparam logic [7:0]  FC_NOP         = 8'h7E;
    localparam logic [7:0]  ERR_FLAG       = 8'h80;
    localparam logic [7:0]  EXC_ILL_FUNC   = 8'h01;
    localparam logic [7:0]  EXC_ILL_ADDR   = 8'h02;
    localparam logic [7:0]  EXC_ILL_DATA   = 8'h03;
    localparam logic [15:0] REG_LOGIC_CMD  = 16'h2000;
    localparam logic [15:0] REG_STATUS_LO  = 16'h2100;
    localparam logic [15:0] REG_STATUS_HI  = 16'h2101;
    localparam int          STATUS_SEL_BIT = 3;
    localparam int          ENUM_TEXT_LEN  = 16;
    localparam int          MAX_DATA       = 250;
    localparam int          BUF_DEPTH      = 256;
    localparam logic [15:0] CRC_INIT       = 16'hFFFF;
    localparam logic [15:0] CRC_POLY       = 16'hA001;
    localparam logic [15:0] CMD_RESET      = 16'h0000;
endpackage

// ===== common/mbenc_emb_if.sv
/*
 * Request and answer bundle between the handler and its embedded-function
 * engine. Assumes one request in flight.
 */
`timescale 1ns/1ps
`default_nettype none
interface mbenc_emb_if;
    logic       req;
    logic [7:0] func;
    logic [7:0] lenIn;
    logic [7:0] rdIdx;
    logic [7:0] rdByte;
    logic       done;
    logic       fail;
    logic [7:0] excCode;
    logic [7:0] lenOut;
    logic [7:0] outIdx;
    logic [7:0] outByte;
    modport handler (output req, func, lenIn, rdByte, outIdx,
                     input  rdIdx, done, fail, excCode, lenOut, outByte);
    modport engine  (input  req, func, lenIn, rdByte, outIdx,
                     output rdIdx, done, fail, excCode, lenOut, outByte);
endinterface
`default_nettype wire

// ===== design/mbenc_crc16.sv
/*
 * Byte-serial Modbus CRC-16 (reflected, polynomial A001h).
 * Assumes clear and byte strobes come from one process upstream.
 */
`timescale 1ns/1ps
`default_nettype none
module mbenc_crc16 (
    input  wire logic        mclk,
    input  wire logic        resetn,
    input  wire logic        clear,
    input  wire logic        byteEn,
    input  wire logic [7:0]  dataIn,
    output logic      [15:0] crc
);
    logic [15:0] next_crc;

    always_comb begin
        next_crc = crc ^ {8'h00, dataIn};
        for (int i = 0; i < 8; i++) begin
            next_crc = next_crc[0] ? ((next_crc >> 1) ^ mbenc_pkg::CRC_POLY) : (next_crc >> 1);
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            crc <= mbenc_pkg::CRC_INIT;
        end else if (clear) begin
            crc <= mbenc_pkg::CRC_INIT;
        end else if (byteEn) begin
            crc <= next_crc;
        end
    end
endmodule
`default_nettype wire

// ===== design/mbenc_emb_engine.sv
/*
 * Embedded-function engine: runs the no-operation code and refuses the
 * rest as unsupported. Assumes a one-cycle req with the query data present.
 */
`timescale 1ns/1ps
`default_nettype none
module mbenc_emb_engine (
    input  wire logic   mclk,
    input  wire logic   resetn,
    mbenc_emb_if.engine emb
);
    wire isNop = (emb.func == mbenc_pkg::FC_NOP);

    assign emb.rdIdx   = 8'h00;
    assign emb.outByte = 8'h00;
    assign emb.lenOut  = 8'h00;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            emb.done    <= 1'b0;
            emb.fail    <= 1'b0;
            emb.excCode <= 8'h00;
        end else begin
            emb.done    <= emb.req;
            emb.fail    <= emb.req && !isNop;
            emb.excCode <= isNop ? 8'h00 : mbenc_pkg::EXC_ILL_FUNC;
        end
    end
endmodule
`default_nettype wire

// ===== bench/mbenc_handler_asserts.sv
/*
 * Port-level assertions for the enumeration-text and encapsulated handler.
 * Assumes a single clock domain and the bind below onto every handler.
 */
`timescale 1ns/1ps
`default_nettype none
module mbenc_handler_asserts (
    input wire logic        mclk,
    input wire logic        resetn,
    input wire logic        rxValid,
    input wire logic        frameEnd,
    input wire logic        txValid,
    input wire logic [7:0]  txByte,
    input wire logic        txReady,
    input wire logic        txLast,
    input wire logic        logicCommandWr,
    input wire logic [15:0] cntInvalidAddr,
    input wire logic [15:0] cntIllegalReg,
    input wire logic [15:0] cntIllegalFunc
);
    logic endSeen;
    assign endSeen = rxValid && frameEnd;
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    a_last_accepted: assert property (txLast |-> txValid && txReady)
        else $error("txLast outside an accepted byte");
    a_valid_holds: assert property (txValid && !txLast |=> txValid)
        else $error("reply dropped before its last byte");
    a_byte_held: assert property (txValid && !txReady |=> $stable(txByte))
        else $error("txByte changed while stalled");
    a_reply_ends: assert property (txLast |=> !txValid)
        else $error("reply continued after last byte");
    a_reply_cause: assert property ($rose(txValid) |-> $past(endSeen, 3) ||
        $past(endSeen, 4) || $past(endSeen, 5) || $past(endSeen, 6))
        else $error("reply without a preceding frame");
    a_cmd_pulse: assert property (logicCommandWr |=> !logicCommandWr)
        else $error("control write longer than one cycle");
    a_cmd_replies: assert property (logicCommandWr |-> ##[0:4] txValid)
        else $error("control write without reply");
    a_addr_step: assert property ($changed(cntInvalidAddr) |->
        cntInvalidAddr == $past(cntInvalidAddr) + 16'h0001)
        else $error("invalid-address count jumped");
    a_reg_step: assert property ($changed(cntIllegalReg) |->
        cntIllegalReg == $past(cntIllegalReg) + 16'h0001)
        else $error("illegal-register count jumped");
    a_func_step: assert property ($changed(cntIllegalFunc) |->
        cntIllegalFunc == $past(cntIllegalFunc) + 16'h0001)
        else $error("illegal-function count jumped");
endmodule
bind mbenc_handler mbenc_handler_asserts u_asserts (.mclk(mclk), .resetn(resetn),
    .rxValid(rxValid), .frameEnd(frameEnd), .txValid(txValid), .txByte(txByte),
    .txReady(txReady), .txLast(txLast), .logicCommandWr(logicCommandWr),
    .cntInvalidAddr(cntInvalidAddr), .cntIllegalReg(cntIllegalReg),
    .cntIllegalFunc(cntIllegalFunc));
`default_nettype wire

// ===== bench/mbenc_far_model.sv
/*
 * Far-side model: setting lookup and a reply sink that can stall.
 * Assumes the handler samples the lookup combinationally.
 */
`timescale 1ns/1ps
`default_nettype none
module mbenc_far_model (
    input  wire logic        mclk,
    input  wire logic        slow,
    input  wire logic [15:0] paramNumber,
    input  wire logic [7:0]  enumIndex,
    input  wire logic [3:0]  textIdx,
    output logic             paramOk,
    output logic             indexOk,
    output logic      [7:0]  textByte,
    output logic             txReady
);
    assign paramOk  = paramNumber < 16'h0100;
    assign indexOk  = enumIndex < 8'h04;
    assign textByte = 8'h41 + {4'h0, textIdx} + enumIndex;
    // Stall every other cycle when slow
    always @(negedge mclk) begin
        txReady <= slow ? ~txReady : 1'b1;
    end
endmodule
`default_nettype wire

// ===== bench/testbench.sv
/*
 * Self-checking bench for the handler: frames in, replies compared.
 * Assumes the checker is bound by its own file.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin miscompares++; $display("Error %s expected %h seen %h", n, e, g); end end
module testbench;
    typedef logic [7:0] mbenc_q8_t [$];
    logic        mclk, resetn, rxValid, frameEnd, txValid, txReady, txLast, slow;
    logic        logicCommandWr, paramOk, indexOk;
    logic [7:0]  rxByte, txByte, enumIndex, textByte;
    logic [3:0]  textIdx;
    logic [15:0] logicCommand, statusLow, statusHigh, paramNumber, cw, st;
    logic [15:0] cntInvalidAddr, cntIllegalReg, cntIllegalFunc;
    mbenc_q8_t   exp;
    int          miscompares = 0;
    int          total_checks = 0;

    mbenc_handler #(.SLAVE_ADDR(8'h01)) DUT (.mclk(mclk), .resetn(resetn), .rxValid(rxValid),
        .rxByte(rxByte), .frameEnd(frameEnd), .txValid(txValid), .txByte(txByte),
        .txReady(txReady), .txLast(txLast), .logicCommand(logicCommand),
        .logicCommandWr(logicCommandWr), .statusLow(statusLow), .statusHigh(statusHigh),
        .paramNumber(paramNumber), .enumIndex(enumIndex), .textIdx(textIdx),
        .paramOk(paramOk), .indexOk(indexOk), .textByte(textByte),
        .cntInvalidAddr(cntInvalidAddr), .cntIllegalReg(cntIllegalReg),
        .cntIllegalFunc(cntIllegalFunc));
    mbenc_far_model u_far (.mclk(mclk), .slow(slow), .paramNumber(paramNumber),
        .enumIndex(enumIndex), .textIdx(textIdx), .paramOk(paramOk), .indexOk(indexOk),
        .textByte(textByte), .txReady(txReady));

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    function automatic logic [15:0] crc16(input mbenc_q8_t q);
        logic [15:0] c;
        c = 16'hFFFF;
        foreach (q[i]) begin
            c ^= {8'h00, q[i]};
            repeat (8) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
        end
        return c;
    endfunction

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // CRC low byte first; badCrc spoils it
    task automatic send(input mbenc_q8_t q, input logic badCrc);
        logic [15:0] c;
        c = crc16(q) ^ {15'h0000, badCrc};
        q.push_back(c[7:0]);
        q.push_back(c[15:8]);
        foreach (q[i]) begin
            @(negedge mclk);
            rxValid = 1'b1;
            rxByte = q[i];
            frameEnd = (i == q.size() - 1);
        end
        @(negedge mclk);
        rxValid = 1'b0;
        frameEnd = 1'b0;
    endtask

    task automatic expect_reply(input mbenc_q8_t e);
        mbenc_q8_t   got;
        logic [15:0] c;
        logic        lastSeen;
        int          n;
        c = crc16(e);
        e.push_back(c[7:0]);
        e.push_back(c[15:8]);
        n = 0;
        while (n < 400 && got.size() < e.size()) begin
            @(negedge mclk);
            #1;
            n++;
            lastSeen = txLast;
            if (txValid === 1'b1 && txReady === 1'b1) got.push_back(txByte);
        end
        if (n == 400) begin
            miscompares++;
            finish_test();
        end
        foreach (e[i]) `CHK("txByte", e[i], got[i])
        `CHK("txLast", 1'b1, lastSeen)
        @(negedge mclk);
    endtask

    task automatic expect_silence();
        int hits;
        hits = 0;
        repeat (20) begin
            @(negedge mclk);
            if (txValid !== 1'b0) hits++;
        end
        `CHK("silence", 0, hits)
    endtask

    initial begin
        rxValid = 1'b0;
        rxByte = 8'h00;
        frameEnd = 1'b0;
        slow = 1'b0;
        statusLow = 16'hA5C3;
        statusHigh = 16'h3C5A;
        resetn = 1'b0;
        repeat (6) @(posedge mclk);
        @(negedge mclk) resetn = 1'b1;
        `CHK("txValid", 1'b0, txValid)
        `CHK("cntInvalidAddr", 16'h0000, cntInvalidAddr)
        `CHK("logicCommand", 16'h0000, logicCommand)
        send('{8'h01, 8'h62, 8'h00, 8'h12, 8'h02}, 1'b0);
        exp = '{8'h01, 8'h62, 8'h00, 8'h12, 8'h02};
        for (int k = 0; k < mbenc_pkg::ENUM_TEXT_LEN; k++) exp.push_back(8'h43 + k[7:0]);
        expect_reply(exp);
        send('{8'h01, 8'h62, 8'h01, 8'h00, 8'h00}, 1'b0);
        expect_reply('{8'h01, 8'hE2, 8'h02});
        `CHK("cntInvalidAddr", 16'h0001, cntInvalidAddr)
        send('{8'h01, 8'h62, 8'h00, 8'h12, 8'h04}, 1'b0);
        expect_reply('{8'h01, 8'hE2, 8'h03});
        `CHK("cntIllegalReg", 16'h0001, cntIllegalReg)
        // Heartbeat pair, second one stalled by the sink
        for (int k = 0; k < 2; k++) begin
            cw = k ? 16'h000C : 16'h0005;
            st = k ? statusHigh : statusLow;
            slow = (k == 1);
            send('{8'h01, 8'h7D, cw[15:8], cw[7:0], 8'h7E}, 1'b0);
            expect_reply('{8'h01, 8'h7D, st[15:8], st[7:0], 8'h7E});
            `CHK("logicCommand", cw, logicCommand)
        end
        send('{8'h01, 8'h7D, 8'h00, 8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h02}, 1'b0);
        expect_reply('{8'h01, 8'h7D, 8'hA5, 8'hC3, 8'h83, 8'h01});
        `CHK("cntIllegalFunc", 16'h0001, cntIllegalFunc)
        `CHK("logicCommand", 16'h0001, logicCommand)
        send('{8'h01, 8'h62, 8'h00, 8'h12, 8'h02}, 1'b1);
        expect_silence();
        send('{8'h09, 8'h7D, 8'h00, 8'h05, 8'h7E}, 1'b0);
        expect_silence();
        `CHK("logicCommand", 16'h0001, logicCommand)
        finish_test();
    end
endmodule
`default_nettype wire
